//--- hw/adfc_top.sv
// converter function control with axi4-lite register slave
`timescale 1ns/10ps
module adfc_top
	import adfc_pkg::*;
(
	input  wire logic                  clock_i,            // 40 MHz clock
	input  wire logic                  rst_b_i,            // sync reset, active low
	input  wire logic [7:0]            s_axi_awaddr_i,     // write address
	input  wire logic                  s_axi_awvalid_i,    // write address valid
	output logic                       s_axi_awready_o,    // write address ready
	input  wire logic [31:0]           s_axi_wdata_i,      // write data
	input  wire logic [3:0]            s_axi_wstrb_i,      // write strobes
	input  wire logic                  s_axi_wvalid_i,     // write data valid
	output logic                       s_axi_wready_o,     // write data ready
	output logic [1:0]                 s_axi_bresp_o,      // write response
	output logic                       s_axi_bvalid_o,     // write response valid
	input  wire logic                  s_axi_bready_i,     // write response ready
	input  wire logic [7:0]            s_axi_araddr_i,     // read address
	input  wire logic                  s_axi_arvalid_i,    // read address valid
	output logic                       s_axi_arready_o,    // read address ready
	output logic [31:0]                s_axi_rdata_o,      // read data
	output logic [1:0]                 s_axi_rresp_o,      // read response
	output logic                       s_axi_rvalid_o,     // read data valid
	input  wire logic                  s_axi_rready_i,     // read data ready
	input  wire logic                  external_trigger_pin_i, // trigger input
	input  wire logic [ADFC_RES_W-1:0] adc_data_i,         // analog core result
	output logic [2:0]                 mux_sel_o,          // analog input select
	output logic                       sel_ex_return_o,    // convert return pin
	output logic                       extended_input_out_o,  // route input out
	output logic                       ladder_connect_o,   // ladder to reference
	output logic                       sample_o,           // sample strobe
	output logic                       busy_o              // conversion running
);
	// register state
	logic [7:0]  ctrl_one_q;     // channel, trigger, start
	logic [7:0]  ctrl_two_q;     // bits, ladder, path
	logic [7:0]  ctrl_three_q;   // sample-hold
	logic [ADFC_RES_W-1:0] raw_q [ADFC_NCHAN];  // raw per-channel results
	logic [7:0]  res_bits_q;     // resolution each result was taken at
	adfc_state_t state_q;        // sequencer state
	logic [5:0]  cyc_q;          // conversion cycle counter
	logic        trig_prev_q;    // last trigger pin level
	logic [5:0]  settle_q;       // ladder settle counter
	logic        conv_ex_q;      // current conversion on return pin
	logic [2:0]  dest_q;         // destination register

	// axi handshake state
	logic        aw_got_q;
	logic        w_got_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;

	// derived fields
	logic        bits_w;
	logic        smp_w;
	logic [1:0]  opa_w;
	logic        trig_w;
	logic        start_w;
	logic [2:0]  chan_w;
	logic [5:0]  conv_len_w;
	logic        fall_w;
	logic        wr_fire_w;
	logic [31:0] rd_word_w;
	logic [31:0] fmt_w;
	logic [ADFC_RES_W-1:0] rd_raw_w;
	logic        rd_bits_w;

	assign bits_w  = ctrl_two_q[ADFC_B_BITS];
	assign opa_w   = ctrl_two_q[ADFC_B_OPA +: 2];
	assign smp_w   = ctrl_three_q[ADFC_B_SMP];
	assign trig_w  = ctrl_one_q[ADFC_B_TRIG];
	assign start_w = ctrl_one_q[ADFC_B_START];
	assign chan_w  = ctrl_one_q[ADFC_B_CHAN +: ADFC_W_CHAN];
	assign fall_w  = trig_prev_q & ~external_trigger_pin_i;

	// length of one pin conversion, from sample-hold and resolution, same on every path
	function automatic logic [5:0] conv_len(input logic sample_hold_enable, input logic bits);
		if (sample_hold_enable) begin
			conv_len = bits ? ADFC_CYC_SH10 : ADFC_CYC_SH8;
		end else begin
			conv_len = bits ? ADFC_CYC_NS10 : ADFC_CYC_NS8;
		end
	endfunction
	assign conv_len_w = conv_len(smp_w, bits_w);

	// byte-lane merge for a write
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge = s[0] ? d[7:0] : old;
	endfunction

	// write address and data are accepted independently
	assign wr_fire_w  = aw_got_q & w_got_q & ~s_axi_bvalid_o;

	// write channel capture
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			aw_got_q        <= 1'b0;
			w_got_q         <= 1'b0;
			aw_addr_q       <= 8'h00;
			w_data_q        <= 32'h0000_0000;
			w_strb_q        <= 4'h0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin  // address taken
				aw_got_q        <= 1'b1;
				aw_addr_q       <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin    // data taken
				w_got_q        <= 1'b1;
				w_data_q       <= s_axi_wdata_i;
				w_strb_q       <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin    // reopen after response
				aw_got_q        <= 1'b0;
				w_got_q         <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	// write response, unmapped addresses answer slave error
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= ADFC_RESP_OK;
		end else if (wr_fire_w) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= (aw_addr_q == ADFC_OFS_CTRL_ONE ||
				aw_addr_q == ADFC_OFS_CTRL_TWO || aw_addr_q == ADFC_OFS_CTRL_THREE)
				? ADFC_RESP_OK : ADFC_RESP_ERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// control registers; hardware clears start in one-shot use is not modelled
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			ctrl_one_q   <= 8'h00;
			ctrl_two_q   <= 8'h00;
			ctrl_three_q <= 8'h00;
		end else if (wr_fire_w) begin
			case (aw_addr_q)
				ADFC_OFS_CTRL_ONE:   ctrl_one_q   <= merge(ctrl_one_q, w_data_q, w_strb_q);
				ADFC_OFS_CTRL_TWO:   ctrl_two_q   <= merge(ctrl_two_q, w_data_q, w_strb_q);
				ADFC_OFS_CTRL_THREE: ctrl_three_q <= merge(ctrl_three_q, w_data_q, w_strb_q);
				default: begin
				end
			endcase
		end
	end

	// ladder settle counter; start before it expires still proceeds,
	// software owns the wait, the counter is only shown in status
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			settle_q <= 6'h00;
		end else if (!ladder_connect_o) begin
			settle_q <= 6'(ADFC_SETTLE_CYC);
		end else if (settle_q != 6'h00) begin
			settle_q <= settle_q - 6'h01;
		end
	end

	// trigger pin history for falling edge detect
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			trig_prev_q <= 1'b1;
		end else begin
			trig_prev_q <= external_trigger_pin_i;
		end
	end

	// sequencer: arm on start flag, wait trigger, count conversion
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			state_q   <= ADFC_IDLE;
			cyc_q     <= 6'h00;
			conv_ex_q <= 1'b0;
			dest_q    <= 3'h0;
			sample_o  <= 1'b0;
		end else begin
			sample_o <= 1'b0;
			case (state_q)
				ADFC_IDLE: begin
					if (start_w && ladder_connect_o) begin
						state_q <= ADFC_ARM;
					end
				end
				ADFC_ARM: begin
					if (!start_w) begin
						state_q <= ADFC_IDLE;
					end else if (!trig_w || fall_w) begin
						state_q <= ADFC_CONV;
						cyc_q   <= conv_len_w - 6'h01;
						sample_o <= 1'b1;
						// extended pins chosen from the path field on leaving arm: every conversion with pin trigger, only the first of a run without
						case (opa_w)
							ADFC_OPA_EX0: begin
								conv_ex_q <= 1'b0;
								dest_q    <= 3'h0;
							end
							ADFC_OPA_EX1: begin
								conv_ex_q <= 1'b1;
								dest_q    <= 3'h1;
							end
							ADFC_OPA_AMP: begin
								conv_ex_q <= 1'b1;
								dest_q    <= chan_w;
							end
							default: begin
								conv_ex_q <= 1'b0;
								dest_q    <= chan_w;
							end
						endcase
					end
				end
				ADFC_CONV: begin
					if (!start_w) begin                          // stop on flag clear
						state_q <= ADFC_IDLE;
					end else if (cyc_q == 6'h00) begin
						state_q <= trig_w ? ADFC_ARM : ADFC_CONV;
						cyc_q   <= conv_len_w - 6'h01;
						sample_o <= ~trig_w;
					end else begin
						cyc_q <= cyc_q - 6'h01;
					end
				end
				default: state_q <= ADFC_IDLE;
			endcase
		end
	end

	// result capture at the end of each conversion, with its resolution
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < ADFC_NCHAN; i++) begin
				raw_q[i] <= '0;
			end
			res_bits_q <= 8'h00;
		end else if (state_q == ADFC_CONV && start_w && cyc_q == 6'h00) begin
			raw_q[dest_q]      <= adc_data_i;
			res_bits_q[dest_q] <= bits_w;
		end
	end

	// analog routing outputs registered
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			mux_sel_o            <= 3'h0;
			sel_ex_return_o      <= 1'b0;
			extended_input_out_o <= 1'b0;
			ladder_connect_o     <= 1'b0;
			busy_o               <= 1'b0;
		end else begin
			mux_sel_o            <= chan_w;
			sel_ex_return_o      <= conv_ex_q;
			extended_input_out_o <= (opa_w == ADFC_OPA_AMP);
			ladder_connect_o     <= ctrl_two_q[ADFC_B_LADDER];
			busy_o               <= (state_q == ADFC_CONV);
		end
	end

	// read path: pick raw result, format by its resolution
	assign rd_raw_w  = raw_q[s_axi_araddr_i[4:2]];
	assign rd_bits_w = res_bits_q[s_axi_araddr_i[4:2]];

	adfc_result_fmt u_fmt (
		.raw_i  (rd_raw_w),
		.bits_i (rd_bits_w),
		.word_o (fmt_w)
	);

	// read decode
	always_comb begin
		rd_word_w = 32'h0000_0000;
		case (s_axi_araddr_i)
			ADFC_OFS_CTRL_ONE:   rd_word_w[7:0] = ctrl_one_q;
			ADFC_OFS_CTRL_TWO:   rd_word_w[7:0] = ctrl_two_q;
			ADFC_OFS_CTRL_THREE: rd_word_w[7:0] = ctrl_three_q;
			ADFC_OFS_STATUS:     rd_word_w[7:0] = {busy_o, (settle_q == 6'h00),
				4'h0, state_q};
			default: begin
				if (s_axi_araddr_i[7:5] == ADFC_OFS_RESULT[7:5] &&
					s_axi_araddr_i[1:0] == 2'h0) begin
					rd_word_w = fmt_w;
				end
			end
		endcase
	end

	// read channel: one-cycle answer
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= ADFC_RESP_OK;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rdata_o   <= rd_word_w;
			s_axi_rresp_o   <= (s_axi_araddr_i[1:0] != 2'h0 ||
				(s_axi_araddr_i > ADFC_OFS_STATUS && s_axi_araddr_i[7:5] !=
				ADFC_OFS_RESULT[7:5])) ? ADFC_RESP_ERR : ADFC_RESP_OK;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end
endmodule // adfc_top

//--- common/adfc_pkg.sv
// package of constants for the converter function control block
package adfc_pkg;
	// register byte offsets
	localparam logic [7:0] ADFC_OFS_CTRL_ONE   = 8'h00;
	localparam logic [7:0] ADFC_OFS_CTRL_TWO   = 8'h04;
	localparam logic [7:0] ADFC_OFS_CTRL_THREE = 8'h08;
	localparam logic [7:0] ADFC_OFS_STATUS     = 8'h0c;
	localparam logic [7:0] ADFC_OFS_RESULT     = 8'h20;
	// control one fields
	localparam int ADFC_B_CHAN     = 0;
	localparam int ADFC_W_CHAN     = 3;
	localparam int ADFC_B_TRIG     = 5;
	localparam int ADFC_B_START    = 6;
	// control two fields
	localparam int ADFC_B_BITS     = 3;
	localparam int ADFC_B_LADDER   = 5;
	localparam int ADFC_B_OPA      = 6;
	// control three fields
	localparam int ADFC_B_SMP      = 0;
	// amplifier path select encodings
	localparam logic [1:0] ADFC_OPA_OFF  = 2'h0;
	localparam logic [1:0] ADFC_OPA_EX0  = 2'h1;
	localparam logic [1:0] ADFC_OPA_EX1  = 2'h2;
	localparam logic [1:0] ADFC_OPA_AMP  = 2'h3;
	// conversion cycle counts
	localparam logic [5:0] ADFC_CYC_SH8   = 6'h1c;
	localparam logic [5:0] ADFC_CYC_SH10  = 6'h21;
	localparam logic [5:0] ADFC_CYC_NS8   = 6'h31;
	localparam logic [5:0] ADFC_CYC_NS10  = 6'h3b;
	// result width and channel count
	localparam int ADFC_RES_W   = 10;
	localparam int ADFC_NCHAN   = 8;
	// ladder settle time in ns and cycles at 40 MHz
	localparam int ADFC_CLK_NS     = 25;
	localparam int ADFC_SETTLE_NS  = 1000;
	localparam int ADFC_SETTLE_CYC = (ADFC_SETTLE_NS + ADFC_CLK_NS - 1) / ADFC_CLK_NS;
	// axi responses
	localparam logic [1:0] ADFC_RESP_OK  = 2'h0;
	localparam logic [1:0] ADFC_RESP_ERR = 2'h2;
	// sequencer states
	typedef enum logic [1:0] {ADFC_IDLE, ADFC_ARM, ADFC_CONV} adfc_state_t;
endpackage

//--- hw/adfc_result_fmt.sv
// result placement by resolution into a 32-bit register word
`timescale 1ns/10ps
module adfc_result_fmt
	import adfc_pkg::*;
(
	input  wire logic [ADFC_RES_W-1:0] raw_i,   // raw ten-bit sample
	input  wire logic                  bits_i,  // 1: ten-bit placement
	output logic      [31:0]           word_o   // formatted word
);
	// eight-bit mode keeps the top eight of ten, upper bits zero
	always_comb begin
		word_o = 32'h0000_0000;
		if (bits_i) begin
			word_o[ADFC_RES_W-1:0] = raw_i;
		end else begin
			word_o[7:0] = raw_i[ADFC_RES_W-1:2];
		end
	end
endmodule // adfc_result_fmt

//--- tb/adfc_sensor_model.sv
// behavioural sensors and external amplifier feeding the converter core
`timescale 1ns/10ps
module adfc_sensor_model
	import adfc_pkg::*;
(
	input  wire logic                  ex_return_i, // return pin converted
	input  wire logic                  ex_out_i,    // input routed out
	output logic      [ADFC_RES_W-1:0] adc_data_o   // core result
);
	// the amplifier only returns a signal while the input is routed out to it
	always_comb begin
		if (ex_return_i && ex_out_i) begin
			adc_data_o = 10'h3a8;
		end else if (ex_return_i) begin
			adc_data_o = 10'h1c3; // plain return pin level
		end else begin
			adc_data_o = 10'h2b6; // sensor level, same on every pin
		end
	end
endmodule // adfc_sensor_model

//--- tb/adfc_top_props.sv
// port assertions for the converter function control block
`timescale 1ns/10ps
module adfc_top_props
	import adfc_pkg::*;
(
	input wire logic        clock_i,              // clock
	input wire logic        rst_b_i,              // sync reset
	input wire logic        s_axi_awvalid_i,      // aw valid
	input wire logic        s_axi_awready_o,      // aw ready
	input wire logic        s_axi_wvalid_i,       // w valid
	input wire logic        s_axi_wready_o,       // w ready
	input wire logic        s_axi_bvalid_o,       // b valid
	input wire logic        s_axi_bready_i,       // b ready
	input wire logic        s_axi_arvalid_i,      // ar valid
	input wire logic        s_axi_arready_o,      // ar ready
	input wire logic        s_axi_rvalid_o,       // r valid
	input wire logic        s_axi_rready_i,       // r ready
	input wire logic [31:0] s_axi_rdata_o,        // r data
	input wire logic        sel_ex_return_o,      // return pin
	input wire logic        extended_input_out_o, // routed out
	input wire logic        ladder_connect_o,     // ladder
	input wire logic        sample_o,             // strobe
	input wire logic        busy_o                // converting
);
	logic [5:0] gap_q; // cycles since last strobe, saturating
	// starts saturated so the first strobe after reset is never judged
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			gap_q <= 6'h3f;
		end else if (sample_o) begin
			gap_q <= 6'h00;
		end else if (!busy_o) begin
			gap_q <= 6'h3f;    // a fresh run is not judged against the last one
		end else if (gap_q != 6'h3f) begin
			gap_q <= gap_q + 6'h01;
		end
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	sequence wr_taken;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence rd_taken;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence
	write_answer_a: assert property (wr_taken |=> !s_axi_awready_o ##1
		(s_axi_bvalid_o && !s_axi_awready_o))
		else $error("write not answered");
	bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
		else $error("write response dropped");
	read_answer_a: assert property (rd_taken |=> s_axi_rvalid_o && !s_axi_arready_o)
		else $error("read not answered");
	rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
		s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data moved");
	start_gate_a: assert property (!ladder_connect_o |-> !sample_o)
		else $error("conversion with ladder cut");
	sample_pulse_a: assert property (sample_o |=> !sample_o)
		else $error("strobe longer than a cycle");
	conv_len_a: assert property (sample_o |-> gap_q >= ADFC_CYC_SH8 - 6'h01)
		else $error("conversion too short");
	conv_busy_a: assert property (sample_o |-> ##[0:1] busy_o)
		else $error("strobe without busy");
	amp_route_a: assert property (busy_o && extended_input_out_o |-> sel_ex_return_o)
		else $error("amplifier loop not converted");
endmodule // adfc_top_props

bind adfc_top adfc_top_props i_props (.clock_i, .rst_b_i, .s_axi_awvalid_i, .s_axi_awready_o,
	.s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
	.s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .sel_ex_return_o,
	.extended_input_out_o, .ladder_connect_o, .sample_o, .busy_o);

//--- tb/testbench.sv
// self-checking bench driving the control block over its register bus
`timescale 1ns/10ps
module testbench;
	import adfc_pkg::*;
	logic                  clock_i, rst_b_i, external_trigger_pin_i;
	logic [7:0]            s_axi_awaddr_i, s_axi_araddr_i;
	logic                  s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
	logic                  s_axi_arvalid_i, s_axi_rready_i;
	logic                  s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic                  s_axi_arready_o, s_axi_rvalid_o;
	logic [31:0]           s_axi_wdata_i, s_axi_rdata_o, d;
	logic [1:0]            s_axi_bresp_o, s_axi_rresp_o;
	logic [ADFC_RES_W-1:0] adc_data_i;
	logic [2:0]            mux_sel_o;
	logic                  sel_ex_return_o, extended_input_out_o, ladder_connect_o;
	logic                  sample_o, busy_o;
	int                    errors, n_checks;
	adfc_top i_adfc_top (.clock_i, .rst_b_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
		.s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i,
		.s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
		.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
		.s_axi_rready_i, .external_trigger_pin_i, .adc_data_i, .mux_sel_o, .sel_ex_return_o,
		.extended_input_out_o, .ladder_connect_o, .sample_o, .busy_o);
	adfc_sensor_model i_model (.ex_return_i(sel_ex_return_o), .ex_out_i(extended_input_out_o),
		.adc_data_o(adc_data_i));
	// free running 40 MHz clock
	always #12.5 clock_i = ~clock_i;
	task results;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	// every wait is bounded; a hang ends the run as a mismatch
	task automatic guard(inout int n);
		n++;
		if (n > 300) begin
			errors++;
			results();
		end
	endtask
	task automatic tick(inout int n);
		@(posedge clock_i);
		guard(n);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= v;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		do begin
			tick(n);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
		end while (s_axi_awvalid_i || s_axi_wvalid_i);
		while (!s_axi_bvalid_o) tick(n);
		s_axi_bready_i <= 1'b1;
		@(posedge clock_i);
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp_o});
		s_axi_bready_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
		int n;
		n = 0;
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		do tick(n); while (!s_axi_arready_o);
		s_axi_arvalid_i <= 1'b0;
		do tick(n); while (!s_axi_rvalid_o);
		s_axi_rready_i <= 1'b1;
		@(posedge clock_i);
		v = s_axi_rdata_o;
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp_o});
		s_axi_rready_i <= 1'b0;
	endtask
	// level 1 waits for a start strobe, level 0 for the converter to go idle
	task automatic await(input logic lvl);
		int n;
		n = 0;
		do tick(n); while (lvl ? !sample_o : busy_o);
	endtask
	task automatic conv(input string t, input logic [7:0] c1, input int len);
		int n;
		n = 0;
		wr(ADFC_OFS_CTRL_ONE, {24'h00_0000, c1 | 8'h40}, ADFC_RESP_OK);
		await(1'b1);
		if (c1[2:0] != 3'h0) chk("channel", {29'h0, c1[2:0]}, {29'h0, mux_sel_o});
		// cycles from one start strobe to the next in repeated conversion
		do tick(n); while (!sample_o);
		chk("conversion length", len, n);
		repeat (80) @(posedge clock_i);
		wr(ADFC_OFS_CTRL_ONE, {24'h00_0000, c1}, ADFC_RESP_OK);
		await(1'b0);
		$display("%s done", t);
	endtask
	initial begin
		{clock_i, rst_b_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 5'h00;
		{s_axi_arvalid_i, s_axi_rready_i, errors, n_checks} = '0;
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
		external_trigger_pin_i = 1'b1;
		repeat (20) @(posedge clock_i);
		rst_b_i <= 1'b1;
		@(posedge clock_i);
		// unmapped places are refused
		wr(8'h14, 32'h0000_0001, ADFC_RESP_ERR);
		rd(8'h10, ADFC_RESP_ERR, d);
		chk("unmapped data", 32'h0000_0000, d);
		$display("unmapped test done");
		// start with the ladder cut must not convert
		wr(ADFC_OFS_CTRL_ONE, 32'h0000_0045, ADFC_RESP_OK);
		repeat (40) @(posedge clock_i);
		chk("busy cut", 32'h0000_0000, {31'h0, busy_o});
		chk("ladder cut", 32'h0000_0000, {31'h0, ladder_connect_o});
		wr(ADFC_OFS_CTRL_ONE, 32'h0000_0005, ADFC_RESP_OK);
		wr(ADFC_OFS_CTRL_THREE, 32'h0000_0001, ADFC_RESP_OK);
		wr(ADFC_OFS_CTRL_TWO, 32'h0000_0028, ADFC_RESP_OK);
		repeat (ADFC_SETTLE_CYC + 1) @(posedge clock_i);
		chk("ladder on", 32'h0000_0001, {31'h0, ladder_connect_o});
		rd(ADFC_OFS_STATUS, ADFC_RESP_OK, d);
		chk("settled", 32'h0000_0040, d);
		$display("ladder test done");
		conv("ten bit", 8'h05, ADFC_CYC_SH10);
		rd(8'h34, ADFC_RESP_OK, d);
		chk("ten bit", 32'h0000_02b6, d);
		wr(ADFC_OFS_CTRL_TWO, 32'h0000_0020, ADFC_RESP_OK);
		conv("eight bit", 8'h05, ADFC_CYC_SH8);
		rd(8'h34, ADFC_RESP_OK, d);
		chk("eight bit", 32'h0000_00ad, d);
		wr(ADFC_OFS_CTRL_TWO, 32'h0000_0068, ADFC_RESP_OK);
		conv("first extended", 8'h03, ADFC_CYC_SH10);
		rd(8'h20, ADFC_RESP_OK, d);
		chk("first extended", 32'h0000_02b6, d);
		wr(ADFC_OFS_CTRL_TWO, 32'h0000_00a8, ADFC_RESP_OK);
		conv("second extended", 8'h03, ADFC_CYC_SH10);
		rd(8'h24, ADFC_RESP_OK, d);
		chk("second extended", 32'h0000_01c3, d);
		wr(ADFC_OFS_CTRL_TWO, 32'h0000_00e8, ADFC_RESP_OK);
		conv("amplifier", 8'h03, ADFC_CYC_SH10);
		chk("routed out", 32'h0000_0001, {31'h0, extended_input_out_o});
		chk("return sel", 32'h0000_0001, {31'h0, sel_ex_return_o});
		rd(8'h2c, ADFC_RESP_OK, d);
		chk("amplifier", 32'h0000_03a8, d);
		// pin trigger waits for a falling edge
		wr(ADFC_OFS_CTRL_TWO, 32'h0000_0028, ADFC_RESP_OK);
		wr(ADFC_OFS_CTRL_ONE, 32'h0000_0062, ADFC_RESP_OK);
		repeat (40) @(posedge clock_i);
		chk("no edge", 32'h0000_0000, {31'h0, busy_o});
		external_trigger_pin_i <= 1'b0;
		await(1'b1);
		repeat (80) @(posedge clock_i);
		wr(ADFC_OFS_CTRL_ONE, 32'h0000_0022, ADFC_RESP_OK);
		await(1'b0);
		external_trigger_pin_i <= 1'b1;
		rd(8'h28, ADFC_RESP_OK, d);
		chk("pin trigger", 32'h0000_02b6, d);
		$display("trigger test done");
		results();
	end
endmodule // testbench
